// ==== rtl/tfr_framer.sv ====
/*
  Touch report framer: builds 18-byte touch and maximum-touches packets,
  keeps the touch limit, power state, scan timestamp and attention line.
  Assumes same-clock upstream touch logic and byte sink, AXI4-Lite master.
*/
`timescale 1ns/10ps
module tfr_framer (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       tch_wr_en,
  input  wire logic [tfr_pkg::TIDX_W-1:0] tch_wr_idx,
  input  wire logic [7:0]                 tch_wr_id,
  input  wire logic [11:0]                tch_wr_x,
  input  wire logic [11:0]                tch_wr_y,
  input  wire logic [11:0]                tch_wr_cx,
  input  wire logic [11:0]                tch_wr_cy,
  input  wire logic [7:0]                 tch_wr_width,
  input  wire logic [7:0]                 tch_wr_height,
  input  wire logic                       frame_start,
  input  wire logic [tfr_pkg::CNT_W-1:0]  frame_count,
  output logic                            frame_ready,
  input  wire logic                       maxrpt_rd_req,
  input  wire logic                       maxrpt_wr_valid,
  input  wire logic [7:0]                 maxrpt_wr_value,
  input  wire logic                       power_cmd_valid,
  input  wire logic                       power_cmd_sleep,
  input  wire logic                       object_protocol_message,
  output logic      [7:0]                 rpt_data,
  output logic                            rpt_valid,
  input  wire logic                       rpt_ready,
  output logic                            rpt_last,
  output logic                            host_attention_line_o,
  output logic                            host_attention_line_oe_n,
  output logic                            low_power
);
  import tfr_pkg::*;

  function automatic logic [CNT_W-1:0] min_cnt(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    min_cnt = (a < b) ? a : b;
  endfunction : min_cnt

  function automatic logic [7:0] touch_byte(input logic [4:0]       idx,
                                            input logic [ENT_W-1:0] ent,
                                            input logic             geom,
                                            input logic             nt,
                                            input logic             first,
                                            input logic [CNT_W-1:0] cnt,
                                            input logic [15:0]      ts);
    touch_byte = 8'h00;
    case (idx)
      B_RPTID:  touch_byte = TOUCH_REPORT_IDENTIFIER;
      B_STATUS: touch_byte = {7'h00, ~nt};
      B_TID:    touch_byte = ent[ENT_ID +: 8];
      B_XL:     touch_byte = ent[ENT_X +: 8];
      B_XH:     touch_byte = {4'h0, ent[ENT_X+8 +: 4]};
      B_CXL:    touch_byte = geom ? ent[ENT_CX +: 8] : 8'h00;
      B_CXH:    touch_byte = geom ? {4'h0, ent[ENT_CX+8 +: 4]} : 8'h00;
      B_YL:     touch_byte = ent[ENT_Y +: 8];
      B_YH:     touch_byte = {4'h0, ent[ENT_Y+8 +: 4]};
      B_CYL:    touch_byte = geom ? ent[ENT_CY +: 8] : 8'h00;
      B_CYH:    touch_byte = geom ? {4'h0, ent[ENT_CY+8 +: 4]} : 8'h00;
      B_WID:    touch_byte = geom ? ent[ENT_WIDTH +: 8] : 8'h00;
      B_HGT:    touch_byte = geom ? ent[ENT_HGT +: 8] : 8'h00;
      B_TSL:    touch_byte = ts[7:0];
      B_TSH:    touch_byte = ts[15:8];
      B_CNT:    touch_byte = first ? {3'h0, cnt} : 8'h00;
      default:  touch_byte = 8'h00;
    endcase
  endfunction : touch_byte

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == REG_CTRL) || (a == REG_CFG) || (a == REG_STATUS) || (a == REG_SCAN);
  endfunction : addr_known

  tfr_state_t       state_reg;
  tfr_state_t       state_next;
  logic             geom_reg;
  logic [CNT_W-1:0] cfg_max_reg;
  logic [CNT_W-1:0] limit_reg;
  logic [TICK_CNT_W-1:0] tick_cnt_reg;
  logic [15:0]      scan_time_reg;
  logic [15:0]      grp_time_reg;
  logic [CNT_W-1:0] grp_n_reg;
  logic             no_touch_reg;
  logic             kind_max_reg;
  logic             maxrpt_pend_reg;
  logic [TIDX_W-1:0] touch_idx_reg;
  logic [4:0]       byte_idx_reg;
  logic [ENT_W-1:0] ent_rd;
  logic [ENT_W-1:0] ent_use;
  logic [CNT_W-1:0] pkt_total;
  logic             tick;
  logic             frame_fire;
  logic             start_max;
  logic             byte_taken;
  logic             pkt_end;
  logic             more_pkts;
  logic [7:0]       byte_val;
  logic             aw_full_reg;
  logic             w_full_reg;
  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             wr_fire;

  tfr_touch_mem u_mem (
    .aclk    (aclk),
    .wr_en   (tch_wr_en),
    .wr_idx  (tch_wr_idx),
    .wr_data ({tch_wr_height, tch_wr_width, tch_wr_cy, tch_wr_cx, tch_wr_y, tch_wr_x, tch_wr_id}),
    .rd_en   (state_reg == ST_LOAD),
    .rd_idx  (touch_idx_reg),
    .rd_data (ent_rd)
  );

  assign tick       = (tick_cnt_reg == TICK_CNT_W'(TICK_CYCLES - 1));
  assign frame_fire = frame_start && frame_ready;
  assign start_max  = (state_reg == ST_IDLE) && maxrpt_pend_reg;
  assign byte_taken = (state_reg == ST_SEND) && rpt_valid && rpt_ready;
  assign pkt_end    = byte_taken && (byte_idx_reg == B_CNT);
  assign pkt_total  = no_touch_reg ? CNT_W'(1) : grp_n_reg;
  assign more_pkts  = !kind_max_reg && (({1'b0, touch_idx_reg} + 5'h01) < pkt_total);
  assign ent_use    = no_touch_reg ? '0 : ent_rd;
  assign wr_fire    = aw_full_reg && w_full_reg && !s_axi_bvalid;

  always_comb begin
    if (kind_max_reg) begin
      byte_val = (byte_idx_reg == B_RPTID) ? MAXT_REPORT_IDENTIFIER :
                 (byte_idx_reg == B_MAXT) ? {3'h0, limit_reg} : 8'h00;
    end else begin
      byte_val = touch_byte(byte_idx_reg, ent_use, geom_reg, no_touch_reg,
                            touch_idx_reg == '0, grp_n_reg, grp_time_reg);
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_max) begin
          state_next = ST_SEND;
        end else if (frame_fire) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD: state_next = ST_SEND;
      ST_SEND: begin
        if (pkt_end) begin
          state_next = more_pkts ? ST_LOAD : ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // packet sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ST_IDLE;
      kind_max_reg  <= 1'b0;
      touch_idx_reg <= '0;
      byte_idx_reg  <= '0;
      grp_n_reg     <= '0;
      no_touch_reg  <= 1'b0;
      grp_time_reg  <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (start_max) begin
        kind_max_reg <= 1'b1;
        byte_idx_reg <= B_RPTID;
      end else if (state_reg == ST_IDLE && frame_fire) begin
        kind_max_reg  <= 1'b0;
        touch_idx_reg <= '0;
        byte_idx_reg  <= B_RPTID;
        grp_n_reg     <= min_cnt(frame_count, limit_reg);
        no_touch_reg  <= (min_cnt(frame_count, limit_reg) == '0);
        grp_time_reg  <= scan_time_reg;
      end else if (pkt_end) begin
        byte_idx_reg  <= B_RPTID;
        touch_idx_reg <= touch_idx_reg + TIDX_W'(1);
      end else if (byte_taken) begin
        byte_idx_reg <= byte_idx_reg + 5'h01;
      end
    end
  end

  // byte output: load one byte, wait for the sink to take it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpt_valid <= 1'b0;
      rpt_data  <= 8'h00;
      rpt_last  <= 1'b0;
    end else if (state_reg == ST_SEND && !rpt_valid) begin
      rpt_valid <= 1'b1;
      rpt_data  <= byte_val;
      rpt_last  <= (byte_idx_reg == B_CNT);
    end else if (byte_taken) begin
      rpt_valid <= 1'b0;
      rpt_last  <= 1'b0;
    end
  end

  // pending maximum-touches read, request wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maxrpt_pend_reg <= 1'b0;
    end else if (maxrpt_rd_req) begin
      maxrpt_pend_reg <= 1'b1;
    end else if (start_max) begin
      maxrpt_pend_reg <= 1'b0;
    end
  end

  // touch limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_reg <= CFG_MAX_RST;
    end else if (maxrpt_wr_valid) begin
      limit_reg <= (maxrpt_wr_value > {3'h0, cfg_max_reg}) ? cfg_max_reg
                                                           : maxrpt_wr_value[CNT_W-1:0];
    end else if (limit_reg > cfg_max_reg) begin
      limit_reg <= cfg_max_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_power <= 1'b0;
    end else if (power_cmd_valid) begin
      low_power <= power_cmd_sleep;
    end
  end

  // frames accepted only while idle and awake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_ready <= 1'b0;
    end else begin
      frame_ready <= (state_next == ST_IDLE) && !(state_reg == ST_IDLE && frame_fire) &&
                     !maxrpt_rd_req && !maxrpt_pend_reg &&
                     !(power_cmd_valid ? power_cmd_sleep : low_power);
    end
  end

  // 10 kHz timestamp, frozen in low power
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg  <= '0;
      scan_time_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TICK_CNT_W'(1);
      if (tick && !low_power) begin
        scan_time_reg <= scan_time_reg + 16'h0001;
      end
    end
  end

  // open drain: pin value fixed low, enable low pulls the line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_attention_line_o    <= 1'b0;
      host_attention_line_oe_n <= 1'b1;
    end else begin
      host_attention_line_o    <= 1'b0;
      host_attention_line_oe_n <= !((state_reg != ST_IDLE) || maxrpt_pend_reg ||
                                    object_protocol_message);
    end
  end

  // AXI4-Lite write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      awaddr_reg    <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_known(awaddr_reg) ? AXI_OKAY : AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      geom_reg    <= GEOM_RST;
      cfg_max_reg <= CFG_MAX_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      if (awaddr_reg == REG_CTRL) begin
        geom_reg <= wdata_reg[CTRL_GEOM_BIT];
      end
      if (awaddr_reg == REG_CFG) begin
        cfg_max_reg <= (wdata_reg[CNT_W-1:0] > CNT_W'(MAX_TOUCHES)) ? CNT_W'(MAX_TOUCHES)
                                                                   : wdata_reg[CNT_W-1:0];
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= addr_known(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
      s_axi_rdata   <= 32'h0000_0000;
      case (s_axi_araddr)
        REG_CTRL:   s_axi_rdata[CTRL_GEOM_BIT] <= geom_reg;
        REG_CFG:    s_axi_rdata[CNT_W-1:0] <= cfg_max_reg;
        REG_STATUS: begin
          s_axi_rdata[CNT_W-1:0]    <= limit_reg;
          s_axi_rdata[ST_LOWP_BIT]  <= low_power;
          s_axi_rdata[ST_BUSY_BIT]  <= (state_reg != ST_IDLE);
          s_axi_rdata[ST_ATTN_BIT]  <= !host_attention_line_oe_n;
        end
        REG_SCAN:   s_axi_rdata[15:0] <= scan_time_reg;
        default:    s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  property p_status;
    @(posedge aclk) disable iff (!aresetn)
    (rpt_valid && !kind_max_reg && byte_idx_reg == B_STATUS) |-> (rpt_data == {7'h00, ~no_touch_reg});
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_high_bits;
    @(posedge aclk) disable iff (!aresetn)
    (rpt_valid && !kind_max_reg && (byte_idx_reg == B_XH || byte_idx_reg == B_YH))
      |-> (rpt_data[7:4] == 4'h0);
  endproperty
  a_high_bits: assert property (p_high_bits) else $error("coordinate high nibble set");

  property p_reserved;
    @(posedge aclk) disable iff (!aresetn)
    (rpt_valid && !kind_max_reg && !geom_reg && (byte_idx_reg == B_CXL || byte_idx_reg == B_CXH ||
      byte_idx_reg == B_CYL || byte_idx_reg == B_CYH || byte_idx_reg == B_WID ||
      byte_idx_reg == B_HGT)) |-> (rpt_data == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved byte not zero");

  property p_count;
    @(posedge aclk) disable iff (!aresetn)
    (rpt_valid && !kind_max_reg && byte_idx_reg == B_CNT)
      |-> (rpt_data == ((touch_idx_reg == '0) ? {3'h0, grp_n_reg} : 8'h00));
  endproperty
  a_count: assert property (p_count) else $error("packet count byte wrong");

  property p_length;
    @(posedge aclk) disable iff (!aresetn)
    (rpt_valid && rpt_ready && rpt_last) |-> (byte_idx_reg == B_CNT) ##1 !rpt_valid;
  endproperty
  a_length: assert property (p_length) else $error("packet end not at byte 17");

  property p_limit;
    @(posedge aclk) disable iff (!aresetn)
    (limit_reg > cfg_max_reg) |=> (limit_reg <= $past(cfg_max_reg));
  endproperty
  a_limit: assert property (p_limit) else $error("limit above configured maximum");

  property p_attention;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg != ST_IDLE) |=> !host_attention_line_oe_n;
  endproperty
  a_attention: assert property (p_attention) else $error("attention released while busy");

  property p_maxt;
    @(posedge aclk) disable iff (!aresetn)
    (rpt_valid && kind_max_reg && byte_idx_reg == B_MAXT) |-> (rpt_data == {3'h0, limit_reg});
  endproperty
  a_maxt: assert property (p_maxt) else $error("maximum touches byte wrong");

  property p_power;
    @(posedge aclk) disable iff (!aresetn)
    (power_cmd_valid && power_cmd_sleep) |=> low_power && !frame_ready ##1 !frame_ready;
  endproperty
  a_power: assert property (p_power) else $error("sleep command not honoured");

  property p_tick;
    @(posedge aclk) disable iff (!aresetn)
    (tick && !low_power) |=> (scan_time_reg == $past(scan_time_reg) + 16'h0001);
  endproperty
  a_tick: assert property (p_tick) else $error("timestamp did not advance");
endmodule : tfr_framer

// ==== rtl/tfr_pkg.sv ====
/*
  Constants, report layout and register map for the touch report framer.
  Assumes a single 10 MHz clock domain and an AXI4-Lite master with 32-bit data.
*/
package tfr_pkg;
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned TICK_HZ     = 10_000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned TICK_CNT_W  = 10;

  // report identifiers, values arbitrary
  localparam logic [7:0] TOUCH_REPORT_IDENTIFIER = 8'h01;
  localparam logic [7:0] MAXT_REPORT_IDENTIFIER  = 8'h02;

  localparam int unsigned MAX_TOUCHES = 16;
  localparam int unsigned TIDX_W      = 4;
  localparam int unsigned CNT_W       = 5;

  // byte positions inside an 18-byte packet
  localparam logic [4:0] B_RPTID  = 5'h00;
  localparam logic [4:0] B_STATUS = 5'h01;
  localparam logic [4:0] B_TID    = 5'h02;
  localparam logic [4:0] B_XL     = 5'h03;
  localparam logic [4:0] B_XH     = 5'h04;
  localparam logic [4:0] B_CXL    = 5'h05;
  localparam logic [4:0] B_CXH    = 5'h06;
  localparam logic [4:0] B_YL     = 5'h07;
  localparam logic [4:0] B_YH     = 5'h08;
  localparam logic [4:0] B_CYL    = 5'h09;
  localparam logic [4:0] B_CYH    = 5'h0a;
  localparam logic [4:0] B_WID    = 5'h0b;
  localparam logic [4:0] B_HGT    = 5'h0d;
  localparam logic [4:0] B_TSL    = 5'h0f;
  localparam logic [4:0] B_TSH    = 5'h10;
  localparam logic [4:0] B_CNT    = 5'h11;
  localparam logic [4:0] B_MAXT   = 5'h01;

  // touch table entry layout
  localparam int unsigned ENT_W     = 72;
  localparam int unsigned ENT_ID    = 0;
  localparam int unsigned ENT_X     = 8;
  localparam int unsigned ENT_Y     = 20;
  localparam int unsigned ENT_CX    = 32;
  localparam int unsigned ENT_CY    = 44;
  localparam int unsigned ENT_WIDTH = 56;
  localparam int unsigned ENT_HGT   = 64;

  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SCAN   = 8'h0c;

  localparam int unsigned CTRL_GEOM_BIT = 0;
  localparam int unsigned ST_LOWP_BIT   = 8;
  localparam int unsigned ST_BUSY_BIT   = 9;
  localparam int unsigned ST_ATTN_BIT   = 10;

  localparam logic             GEOM_RST    = 1'b0;
  localparam logic [CNT_W-1:0] CFG_MAX_RST = 5'h10;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} tfr_state_t;
endpackage : tfr_pkg

// ==== rtl/tfr_touch_mem.sv ====
/*
  Touch table: one entry per touch slot, registered read data.
  Assumes writer and reader share the framer clock.
*/
`timescale 1ns/10ps
module tfr_touch_mem (
  input  wire logic                       aclk,
  input  wire logic                       wr_en,
  input  wire logic [tfr_pkg::TIDX_W-1:0] wr_idx,
  input  wire logic [tfr_pkg::ENT_W-1:0]  wr_data,
  input  wire logic                       rd_en,
  input  wire logic [tfr_pkg::TIDX_W-1:0] rd_idx,
  output logic      [tfr_pkg::ENT_W-1:0]  rd_data
);
  import tfr_pkg::*;

  logic [ENT_W-1:0] mem [MAX_TOUCHES];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule : tfr_touch_mem

// ==== testbench/test_tfr_framer.sv ====
/* Self-checking bench for tfr_framer: register bus, touch groups, limit.
   Assumes tfr_pkg and the host model are compiled first. */
`timescale 1ns/10ps
module test_tfr_framer;
  import tfr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tch_wr_en, frame_start, frame_ready, maxrpt_rd_req, maxrpt_wr_valid, power_cmd_valid;
  logic power_cmd_sleep, object_protocol_message, rpt_valid, rpt_ready, rpt_last, low_power;
  logic host_attention_line_o, host_attention_line_oe_n, attn_line;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tch_wr_id, tch_wr_width, tch_wr_height, rpt_data;
  logic [7:0] maxrpt_wr_value;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [11:0] tch_wr_x, tch_wr_y, tch_wr_cx, tch_wr_cy;
  logic [3:0] s_axi_wstrb, tch_wr_idx;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] frame_count;
  logic [71:0] ent [3];
  logic [7:0] q [$];
  int failures, checked, cyc;
  tfr_framer DUT (.*);
  tfr_host_model host (.aclk(aclk), .attn_o(host_attention_line_o),
    .attn_oe_n(host_attention_line_oe_n), .rpt_ready(rpt_ready), .attn_line(attn_line));
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rpt_valid && rpt_ready) begin
      cmp("rpt_last", q.size() % 18 == 17, rpt_last);
      q.push_back(rpt_data);
    end
    if (cyc > 6000) begin
      failures++;
      end_sim();
    end
  end
  task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic wr(logic [7:0] a, logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    cmp("bresp", AXI_OKAY, s_axi_bresp);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    cmp("rdata", e, s_axi_rdata);
    cmp("rresp", r, s_axi_rresp);
  endtask : rd
  task automatic drain(int n);
    while (q.size() < n - 1) @(posedge aclk);
    cmp("attn_busy", 0, attn_line);
    while (q.size() < n) @(posedge aclk);
    repeat (3) @(posedge aclk);
    cmp("attn_idle", 1, attn_line);
  endtask : drain
  function automatic logic [7:0] eb(logic [71:0] e, int g, int k, logic f);
    logic [7:0] b [18];
    b = '{TOUCH_REPORT_IDENTIFIER, 8'h01, e[7:0], e[15:8], {4'h0, e[19:16]}, e[39:32], {4'h0, e[43:40]},
          e[27:20], {4'h0, e[31:28]}, e[51:44], {4'h0, e[55:52]}, e[63:56], 8'h00, e[71:64],
          8'h00, 8'h00, 8'h00, f ? 8'h03 : 8'h00};
    if (g == 0 && k inside {5, 6, 9, 10, 11, 13}) return 8'h00;
    return b[k];
  endfunction : eb
  task automatic end_sim();
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, tch_wr_en,
     frame_start, maxrpt_rd_req, maxrpt_wr_valid, power_cmd_valid, power_cmd_sleep} = '0;
    {object_protocol_message, s_axi_awaddr, s_axi_araddr, s_axi_wdata, tch_wr_idx,
     maxrpt_wr_value, frame_count} = '0;
    {tch_wr_height, tch_wr_width, tch_wr_cy, tch_wr_cx, tch_wr_y, tch_wr_x, tch_wr_id} = '0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h55ea));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_STATUS, 32'h10, AXI_OKAY);
    rd(8'h40, 32'h0, AXI_SLVERR);
    for (int i = 0; i < 2; i++) begin
      maxrpt_wr_value <= i ? 8'h03 : 8'h20;
      maxrpt_wr_valid <= 1'b1;
      @(posedge aclk);
      maxrpt_wr_valid <= 1'b0;
      rd(REG_STATUS, i ? 32'h3 : 32'h10, AXI_OKAY);
    end
    maxrpt_rd_req <= 1'b1;
    @(posedge aclk);
    maxrpt_rd_req <= 1'b0;
    drain(18);
    for (int k = 0; k < 18; k++)
      cmp("max_byte", k == 0 ? MAXT_REPORT_IDENTIFIER : k == 1 ? 8'h03 : 8'h00, q[k]);
    for (int g = 0; g < 2; g++) begin
      q.delete();
      wr(REG_CTRL, g);
      while (!frame_ready) @(posedge aclk);
      for (int p = 0; p < 3; p++) begin
        ent[p] = 72'({$urandom, $urandom, $urandom});
        ent[p][7:0] = 8'(p);
        {tch_wr_height, tch_wr_width, tch_wr_cy, tch_wr_cx, tch_wr_y, tch_wr_x, tch_wr_id} <= ent[p];
        {tch_wr_en, tch_wr_idx} <= {1'b1, 4'(p)};
        @(posedge aclk);
      end
      {tch_wr_en, frame_start, frame_count} <= {1'b0, 1'b1, 5'd5};
      @(posedge aclk);
      frame_start <= 1'b0;
      drain(54);
      for (int i = 0; i < 54; i++)
        if (i % 18 < 15 || i % 18 == 17)
          cmp("touch_byte", eb(ent[i / 18], g, i % 18, i < 18), q[i]);
    end
    wr(REG_CFG, 32'h1f);
    rd(REG_CFG, 32'h10, AXI_OKAY);
    wr(REG_CFG, 32'h2);
    rd(REG_STATUS, 32'h2, AXI_OKAY);
    repeat (1000) @(posedge aclk);
    object_protocol_message <= 1'b1;
    repeat (3) @(posedge aclk);
    cmp("attn_msg", 0, attn_line);
    {object_protocol_message, power_cmd_sleep, power_cmd_valid} <= 3'b011;
    @(posedge aclk);
    power_cmd_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    cmp("low_power", 1, low_power);
    cmp("frame_ready", 0, frame_ready);
    end_sim();
  end
endmodule : test_tfr_framer

// ==== testbench/tfr_host_model.sv ====
/* Host side of the report stream: takes bytes with random stalls and
   resolves the open-drain attention wire. Assumes one shared clock. */
`timescale 1ns/10ps
module tfr_host_model (
  input  wire logic aclk,
  input  wire logic attn_o,
  input  wire logic attn_oe_n,
  output logic      rpt_ready,
  output logic      attn_line
);
  // pull-up when released, level read by host
  assign attn_line = attn_oe_n ? 1'b1 : attn_o;
  always @(posedge aclk) rpt_ready <= ($urandom % 3) != 0;
endmodule : tfr_host_model
